// ===== rtl/fsk_shr_consts.svh
`ifndef FSK_SHR_CONSTS_SVH
`define FSK_SHR_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RIDX_FEC_CONTROL 11'h163
`define RIDX_PREAMBLE_LENGTH 11'h440
`define RIDX_PREAMBLE_PATTERN 11'h447
`define RIDX_TX_DELIM_UNCODED 11'h448
`define RIDX_TX_DELIM_CODED 11'h44c
`define RIDX_TX_DELIM_ALT_UNCODED 11'h450
`define RIDX_TX_DELIM_ALT_CODED 11'h454
`define RIDX_SYNC_HEADER_CONTROL 11'h461
`define RIDX_FRAMER_STATUS 11'h470

// ----------------------------------------
// Field positions of fsk_fec_control
// ----------------------------------------
`define FEC_AUTODETECT_BIT 0
`define FEC_TX_ENABLE_BIT 1
`define FEC_ACK_REPLY_CTRL_BIT 2
`define FEC_ACK_REPLY_EN_BIT 3
`define FEC_ACK_RX_CTRL_BIT 4
`define FEC_ACK_RX_EN_BIT 5
`define FEC_SET_SELECT_BIT 6
`define FEC_MONITOR_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FEC_CONTROL 7'h00
`define RST_PREAMBLE_LENGTH 16'h0004
`define RST_PREAMBLE_PATTERN 8'haa
`define RST_TX_DELIM_UNCODED 32'h904e0000
`define RST_TX_DELIM_CODED 32'h6f4e0000
`define RST_TX_DELIM_ALT_UNCODED 32'h7a0e0000
`define RST_TX_DELIM_ALT_CODED 32'h632d0000
`define RST_SYNC_HEADER_CONTROL 2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 10000000
`define BIT_RATE_HZ 100000
`define BIT_CYCLES (`CLK_HZ / `BIT_RATE_HZ)
`define BIT_CNT_W 7
`define PRE_LEN_W 10

`endif

// ===== rtl/fsk_shr_pkg.sv
package fsk_shr_pkg;
	typedef enum logic [1:0] {SER_IDLE, SER_PREAMBLE, SER_DELIM} ser_state_t;
	typedef logic [31:0] delim_word_t;
endpackage

// ===== rtl/shr_link_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsk_shr_consts.svh"

interface shr_link_if;
	logic start;
	logic [`PRE_LEN_W-1:0] pre_len;
	logic [7:0] pre_pat;
	logic [31:0] delim;
	logic [1:0] delim_bytes;
	logic bit_tick;
	logic busy;
	logic done;
	logic tx_bit;
	logic tx_bit_valid;
	modport ctl (output start, pre_len, pre_pat, delim, delim_bytes, bit_tick,
		input busy, done, tx_bit, tx_bit_valid);
	modport ser (input start, pre_len, pre_pat, delim, delim_bytes, bit_tick,
		output busy, done, tx_bit, tx_bit_valid);
endinterface

`default_nettype wire

// ===== rtl/fec_policy.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsk_shr_consts.svh"

module fec_policy
	import fsk_shr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Settings
	input wire logic [6:0] fec_ctrl,
	// Receive results
	input wire logic rx_frame_done,
	input wire logic rx_frame_fec,
	// Frame to send
	input wire logic tx_is_ack,
	// Decisions
	output logic rx_fec_monitor,
	output logic tx_fec_now,
	output logic rx_autodetect_en,
	output logic ack_rx_forced,
	output logic ack_rx_value
);

	wire ack_fec;

	assign rx_autodetect_en = fec_ctrl[`FEC_AUTODETECT_BIT];
	assign ack_fec = fec_ctrl[`FEC_ACK_REPLY_CTRL_BIT]
		? fec_ctrl[`FEC_ACK_REPLY_EN_BIT]
		: rx_fec_monitor;
	assign tx_fec_now = tx_is_ack ? ack_fec : fec_ctrl[`FEC_TX_ENABLE_BIT];
	assign ack_rx_forced = fec_ctrl[`FEC_ACK_RX_CTRL_BIT];
	assign ack_rx_value = fec_ctrl[`FEC_ACK_RX_CTRL_BIT] & fec_ctrl[`FEC_ACK_RX_EN_BIT];

	// Only the receive path updates this bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_fec_monitor <= 1'b0;
		else if (rx_frame_done)
			rx_fec_monitor <= rx_frame_fec;
	end

endmodule

`default_nettype wire

// ===== rtl/shr_serializer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsk_shr_consts.svh"

module shr_serializer
	import fsk_shr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Header job
	shr_link_if.ser link
);

	ser_state_t state, next_state;
	logic [2:0] bit_idx;
	logic [`PRE_LEN_W-1:0] bytes_left;
	logic [1:0] delim_left;
	logic [7:0] pat;
	delim_word_t shift;
	wire byte_end;
	wire last_pre;

	assign byte_end = link.bit_tick && (bit_idx == 3'h7);
	assign last_pre = (bytes_left == `PRE_LEN_W'(1));
	assign link.busy = (state != SER_IDLE);

	always_comb
	begin
		next_state = state;
		unique case (state)
			SER_IDLE:
				if (link.start)
					next_state = (link.pre_len == '0) ? SER_DELIM : SER_PREAMBLE;
			SER_PREAMBLE:
				if (byte_end && last_pre)
					next_state = SER_DELIM;
			SER_DELIM:
				if (byte_end && (delim_left == 2'h0))
					next_state = SER_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SER_IDLE;
			bit_idx <= 3'h0;
			bytes_left <= '0;
			delim_left <= 2'h0;
			pat <= 8'h00;
			shift <= 32'h00000000;
		end
		else
		begin
			state <= next_state;
			if (state == SER_IDLE && link.start)
			begin
				bit_idx <= 3'h0;
				bytes_left <= link.pre_len;
				delim_left <= link.delim_bytes;
				pat <= link.pre_pat;
				shift <= link.delim;
			end
			else if (link.bit_tick && state != SER_IDLE)
			begin
				bit_idx <= bit_idx + 3'h1;
				if (state == SER_DELIM)
					shift <= {shift[30:0], 1'b0};
				if (byte_end && state == SER_PREAMBLE)
					bytes_left <= bytes_left - `PRE_LEN_W'(1);
				if (byte_end && state == SER_DELIM)
					delim_left <= delim_left - 2'h1;
			end
		end
	end

	// Preamble goes out LSB first, delimiter from bit 31 downward
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.tx_bit <= 1'b0;
			link.tx_bit_valid <= 1'b0;
			link.done <= 1'b0;
		end
		else
		begin
			link.tx_bit_valid <= link.bit_tick && (state != SER_IDLE);
			link.done <= (state == SER_DELIM) && (next_state == SER_IDLE);
			if (link.bit_tick && state == SER_PREAMBLE)
				link.tx_bit <= pat[bit_idx];
			else if (link.bit_tick && state == SER_DELIM)
				link.tx_bit <= shift[31];
		end
	end

endmodule

`default_nettype wire

// ===== rtl/fsk_shr_fec_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsk_shr_consts.svh"

module fsk_shr_fec_config
	import fsk_shr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM register slave, word addressed
	input wire logic [10:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Transmit request from the baseband
	input wire logic tx_start,
	input wire logic tx_is_ack,
	// Transmit header stream
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic shr_done,
	output logic tx_busy,
	output logic tx_frame_fec,
	// Receive side
	input wire logic rx_frame_done,
	input wire logic rx_frame_fec,
	output logic rx_autodetect_en,
	output logic ack_rx_forced,
	output logic ack_rx_value,
	output logic delimiter_set_select
);

	// ----------------------------------------
	// Byte-lane merge
	// ----------------------------------------
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		end
		return res;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [6:0] fsk_fec_control;
	logic [15:0] preamble_length;
	logic [7:0] preamble_pattern;
	delim_word_t tx_delimiter_uncoded;
	delim_word_t tx_delimiter_coded;
	delim_word_t tx_delimiter_alt_uncoded;
	delim_word_t tx_delimiter_alt_coded;
	logic [1:0] sync_header_control;

	logic ack;
	logic rx_fec_monitor;
	logic tx_fec_now;
	logic [`BIT_CNT_W-1:0] div_cnt;
	logic bit_tick;
	delim_word_t frame_delim;

	wire access;
	wire wr_en;
	wire rd_take;
	wire hit_fec;
	wire hit_plen;
	wire hit_ppat;
	wire hit_d0;
	wire hit_d1;
	wire hit_d2;
	wire hit_d3;
	wire hit_shr;
	wire hit_stat;
	wire [31:0] rd_mux;
	wire [31:0] fec_word;
	wire [31:0] status_word;
	wire tick_wrap;
	wire start_ok;
	wire wr_fec;
	wire wr_plen;
	wire wr_ppat;
	wire wr_d0;
	wire wr_d1;
	wire wr_d2;
	wire wr_d3;
	wire wr_shr;
	wire [31:0] plen_merged;
	wire [31:0] d0_merged;
	wire [31:0] d1_merged;
	wire [31:0] d2_merged;
	wire [31:0] d3_merged;

	shr_link_if link ();

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait cycle gives the read mux a full period before data leaves
	assign access = (read | write) & ~ack;
	assign waitrequest = (read | write) & ~ack;
	assign wr_en = write & ack;
	assign rd_take = read & ~ack;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ack <= 1'b0;
		else
			ack <= access;
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign hit_fec = (address == `RIDX_FEC_CONTROL);
	assign hit_plen = (address == `RIDX_PREAMBLE_LENGTH);
	assign hit_ppat = (address == `RIDX_PREAMBLE_PATTERN);
	assign hit_d0 = (address == `RIDX_TX_DELIM_UNCODED);
	assign hit_d1 = (address == `RIDX_TX_DELIM_CODED);
	assign hit_d2 = (address == `RIDX_TX_DELIM_ALT_UNCODED);
	assign hit_d3 = (address == `RIDX_TX_DELIM_ALT_CODED);
	assign hit_shr = (address == `RIDX_SYNC_HEADER_CONTROL);
	assign hit_stat = (address == `RIDX_FRAMER_STATUS);

	// ----------------------------------------
	// Write strobes and merged lanes
	// ----------------------------------------
	// Byte-wide and narrower registers take lane 0 only
	assign wr_fec = wr_en & hit_fec & byteenable[0];
	assign wr_plen = wr_en & hit_plen;
	assign wr_ppat = wr_en & hit_ppat & byteenable[0];
	assign wr_d0 = wr_en & hit_d0;
	assign wr_d1 = wr_en & hit_d1;
	assign wr_d2 = wr_en & hit_d2;
	assign wr_d3 = wr_en & hit_d3;
	assign wr_shr = wr_en & hit_shr & byteenable[0];
	assign plen_merged = merge_lanes({16'h0000, preamble_length}, writedata, byteenable);
	assign d0_merged = merge_lanes(tx_delimiter_uncoded, writedata, byteenable);
	assign d1_merged = merge_lanes(tx_delimiter_coded, writedata, byteenable);
	assign d2_merged = merge_lanes(tx_delimiter_alt_uncoded, writedata, byteenable);
	assign d3_merged = merge_lanes(tx_delimiter_alt_coded, writedata, byteenable);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fsk_fec_control <= `RST_FEC_CONTROL;
		else if (wr_fec)
			fsk_fec_control <= writedata[6:0];
	end

	// Length kept as written; only the low ten bits reach the framer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			preamble_length <= `RST_PREAMBLE_LENGTH;
		else if (wr_plen)
			preamble_length <= plen_merged[15:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			preamble_pattern <= `RST_PREAMBLE_PATTERN;
		else if (wr_ppat)
			preamble_pattern <= writedata[7:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_delimiter_uncoded <= `RST_TX_DELIM_UNCODED;
		else if (wr_d0)
			tx_delimiter_uncoded <= d0_merged;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_delimiter_coded <= `RST_TX_DELIM_CODED;
		else if (wr_d1)
			tx_delimiter_coded <= d1_merged;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_delimiter_alt_uncoded <= `RST_TX_DELIM_ALT_UNCODED;
		else if (wr_d2)
			tx_delimiter_alt_uncoded <= d2_merged;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_delimiter_alt_coded <= `RST_TX_DELIM_ALT_CODED;
		else if (wr_d3)
			tx_delimiter_alt_coded <= d3_merged;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_header_control <= `RST_SYNC_HEADER_CONTROL;
		else if (wr_shr)
			sync_header_control <= writedata[1:0];
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	assign fec_word = {24'h000000, rx_fec_monitor, fsk_fec_control};
	assign status_word = {29'h00000000, rx_fec_monitor, tx_frame_fec, tx_busy};
	assign rd_mux = hit_fec ? fec_word
		: hit_plen ? {16'h0000, preamble_length}
		: hit_ppat ? {24'h000000, preamble_pattern}
		: hit_d0 ? tx_delimiter_uncoded
		: hit_d1 ? tx_delimiter_coded
		: hit_d2 ? tx_delimiter_alt_uncoded
		: hit_d3 ? tx_delimiter_alt_coded
		: hit_shr ? {30'h00000000, sync_header_control}
		: hit_stat ? status_word
		: 32'h00000000;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			readdata <= 32'h00000000;
		else if (rd_take)
			readdata <= rd_mux;
	end

	// ----------------------------------------
	// FEC decisions
	// ----------------------------------------
	fec_policy u_policy (
		.clk(clk),
		.rst_n(rst_n),
		.fec_ctrl(fsk_fec_control),
		.rx_frame_done(rx_frame_done),
		.rx_frame_fec(rx_frame_fec),
		.tx_is_ack(tx_is_ack),
		.rx_fec_monitor(rx_fec_monitor),
		.tx_fec_now(tx_fec_now),
		.rx_autodetect_en(rx_autodetect_en),
		.ack_rx_forced(ack_rx_forced),
		.ack_rx_value(ack_rx_value)
	);

	assign delimiter_set_select = fsk_fec_control[`FEC_SET_SELECT_BIT];

	// ----------------------------------------
	// Delimiter selection
	// ----------------------------------------
	assign frame_delim = delimiter_set_select
		? (tx_fec_now ? tx_delimiter_alt_coded : tx_delimiter_alt_uncoded)
		: (tx_fec_now ? tx_delimiter_coded : tx_delimiter_uncoded);

	// Requests while a header is going out are dropped
	assign start_ok = tx_start & ~link.busy;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_frame_fec <= 1'b0;
		else if (start_ok)
			tx_frame_fec <= tx_fec_now;
	end

	// ----------------------------------------
	// Bit-rate divider
	// ----------------------------------------
	// Restarts with each header so the first bit is a full period away
	assign tick_wrap = (div_cnt == `BIT_CNT_W'(`BIT_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt <= '0;
		else if (start_ok || tick_wrap)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + `BIT_CNT_W'(1);
	end

	assign bit_tick = tick_wrap;

	// ----------------------------------------
	// Header serializer
	// ----------------------------------------
	assign link.start = start_ok;
	assign link.pre_len = preamble_length[`PRE_LEN_W-1:0];
	assign link.pre_pat = preamble_pattern;
	assign link.delim = frame_delim;
	assign link.delim_bytes = sync_header_control;
	assign link.bit_tick = bit_tick;

	shr_serializer u_ser (
		.clk(clk),
		.rst_n(rst_n),
		.link(link)
	);

	assign tx_bit = link.tx_bit;
	assign tx_bit_valid = link.tx_bit_valid;
	assign shr_done = link.done;
	assign tx_busy = link.busy;

endmodule

`default_nettype wire

// ===== tb/fsk_shr_fec_config_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module fsk_shr_fec_config_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic write,
	input wire logic waitrequest,
	// Header stream
	input wire logic tx_start,
	input wire logic tx_bit_valid,
	input wire logic shr_done,
	input wire logic tx_busy,
	input wire logic tx_frame_fec,
	// Receive controls
	input wire logic rx_autodetect_en,
	input wire logic ack_rx_forced,
	input wire logic ack_rx_value,
	input wire logic delimiter_set_select
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_ack_value_forced: assert property (ack_rx_value |-> ack_rx_forced)
		else $error("ack receive value without control");
	a_start_busy: assert property (tx_start && !tx_busy |=> tx_busy)
		else $error("accepted start did not raise busy");
	a_first_bit: assert property (
		tx_start && !tx_busy |=> (!tx_bit_valid)[*8] ##93 tx_bit_valid)
		else $error("first header bit not at 101 clocks");
	a_bit_spacing: assert property (tx_bit_valid && tx_busy |-> ##100 tx_bit_valid)
		else $error("header bits not 100 clocks apart");
	a_done_idle: assert property (shr_done |-> !tx_busy ##1 !shr_done)
		else $error("done pulse while busy or too long");
	a_fec_hold: assert property (tx_busy && $past(tx_busy) |-> $stable(tx_frame_fec))
		else $error("fec decision moved during header");
	a_select_by_write: assert property (
		$changed(delimiter_set_select) |-> $past(write && !waitrequest))
		else $error("set select moved without write");
	a_detect_by_write: assert property (
		$changed(rx_autodetect_en) |-> $past(write && !waitrequest))
		else $error("autodetect moved without write");
	a_forced_by_write: assert property (
		$changed(ack_rx_forced) |-> $past(write && !waitrequest))
		else $error("ack receive control moved without write");
endmodule

bind fsk_shr_fec_config fsk_shr_fec_config_monitor mon (.clk(clk), .rst_n(rst_n), .write(write),
	.waitrequest(waitrequest), .tx_start(tx_start), .tx_bit_valid(tx_bit_valid),
	.shr_done(shr_done), .tx_busy(tx_busy), .tx_frame_fec(tx_frame_fec),
	.rx_autodetect_en(rx_autodetect_en), .ack_rx_forced(ack_rx_forced),
	.ack_rx_value(ack_rx_value), .delimiter_set_select(delimiter_set_select));

`default_nettype wire

// ===== tb/air_peer_model.sv
`timescale 1ns/10ps
`default_nettype none

module air_peer_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench control
	input wire logic clear,
	// Air bits
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	// Captured header
	output logic [127:0] bits,
	output logic [7:0] count
);
	// Keeps the newest 128 bits only; longer headers wrap
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bits <= '0;
			count <= 8'h00;
		end
		else if (clear)
		begin
			bits <= '0;
			count <= 8'h00;
		end
		else if (tx_bit_valid)
		begin
			bits <= {bits[126:0], tx_bit};
			count <= count + 8'h01;
		end
	end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsk_shr_consts.svh"

module testbench
	import fsk_shr_pkg::*;
;
	logic clk = 1'h0, rst_n = 1'h0, read = 1'h0, write = 1'h0, clear = 1'h0;
	logic tx_start = 1'h0, tx_is_ack = 1'h0, rx_frame_done = 1'h0, rx_frame_fec = 1'h0;
	logic [10:0] address = 11'h000;
	logic [31:0] writedata = 32'h0, readdata;
	logic [3:0] byteenable = 4'hf;
	logic waitrequest, tx_bit, tx_bit_valid, shr_done, tx_busy, tx_frame_fec;
	logic rx_autodetect_en, ack_rx_forced, ack_rx_value, delimiter_set_select;
	logic [127:0] peer_bits;
	logic [7:0] peer_count;
	int fails = 0, num_checks = 0;

	always #50 clk = ~clk;

	fsk_shr_fec_config dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .tx_start(tx_start), .tx_is_ack(tx_is_ack),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .shr_done(shr_done),
		.tx_busy(tx_busy), .tx_frame_fec(tx_frame_fec), .rx_frame_done(rx_frame_done),
		.rx_frame_fec(rx_frame_fec), .rx_autodetect_en(rx_autodetect_en),
		.ack_rx_forced(ack_rx_forced), .ack_rx_value(ack_rx_value),
		.delimiter_set_select(delimiter_set_select));

	air_peer_model peer (.clk(clk), .rst_n(rst_n), .clear(clear), .tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid), .bits(peer_bits), .count(peer_count));

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bits(input logic [127:0] got, input logic [127:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t header %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until the rising edge that sees waitrequest low
	task automatic bus_xfer(input logic wr, input logic [10:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= idx;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'h0 && n < 50);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (n >= 50)
		begin
			fails++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [10:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus_xfer(1'h1, idx, d, q);
	endtask

	task automatic rd_check(input logic [10:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		bus_xfer(1'h0, idx, 32'h0, q);
		check_word(q, exp);
	endtask

	task automatic rx_pulse(input logic fec);
		@(posedge clk);
		rx_frame_done <= 1'h1;
		rx_frame_fec <= fec;
		@(posedge clk);
		rx_frame_done <= 1'h0;
	endtask

	function automatic logic [127:0] header(input logic [7:0] pat, input int plen,
		input logic [31:0] dl, input int nb);
		logic [127:0] e;
		e = '0;
		for (int i = 0; i < plen; i++)
			for (int b = 0; b < 8; b++)
				e = {e[126:0], pat[b]};
		for (int b = 0; b < nb * 8; b++)
			e = {e[126:0], dl[31 - b]};
		return e;
	endfunction

	// A second start mid-header must be ignored, so poke tests refusal
	task automatic send_frame(input logic ack, input logic poke, input logic [127:0] exp,
		input int nbits, input logic fec);
		int n;
		clear <= 1'h1;
		@(posedge clk);
		clear <= 1'h0;
		tx_start <= 1'h1;
		tx_is_ack <= ack;
		@(posedge clk);
		tx_start <= 1'h0;
		if (poke)
		begin
			repeat (500) @(posedge clk);
			tx_start <= 1'h1;
			@(posedge clk);
			tx_start <= 1'h0;
		end
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (shr_done !== 1'h1 && n < 9000);
		if (n >= 9000)
		begin
			fails++;
			report_and_stop();
		end
		@(negedge clk);
		check_word({24'h0, peer_count}, nbits);
		check_word({31'h0, tx_busy}, 32'h0);
		check_bits(peer_bits, exp);
		check_word({31'h0, tx_frame_fec}, {31'h0, fec});
	endtask

	initial
	begin
		logic [7:0] v;
		logic [7:0] vals [4];
		vals = '{8'hff, 8'h10, 8'h20, 8'h41};
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		rd_check(`RIDX_FEC_CONTROL, 32'h0);
		rd_check(`RIDX_PREAMBLE_LENGTH, 32'h4);
		rd_check(`RIDX_PREAMBLE_PATTERN, 32'haa);
		rd_check(`RIDX_TX_DELIM_UNCODED, 32'h904e0000);
		rd_check(`RIDX_TX_DELIM_CODED, 32'h6f4e0000);
		wr(11'h7ff, 32'h5a);
		rd_check(11'h7ff, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			v = vals[i];
			wr(`RIDX_FEC_CONTROL, {24'h0, v});
			rd_check(`RIDX_FEC_CONTROL, {24'h0, 1'h0, v[6:0]});
			check_word({31'h0, rx_autodetect_en}, {31'h0, v[0]});
			check_word({31'h0, ack_rx_forced}, {31'h0, v[4]});
			check_word({31'h0, ack_rx_value}, {31'h0, v[4] & v[5]});
			check_word({31'h0, delimiter_set_select}, {31'h0, v[6]});
		end
		wr(`RIDX_FEC_CONTROL, 32'h0);
		rx_pulse(1'h1);
		rd_check(`RIDX_FEC_CONTROL, 32'h80);
		wr(`RIDX_FEC_CONTROL, 32'h0);
		rd_check(`RIDX_FEC_CONTROL, 32'h80);
		rx_pulse(1'h0);
		rd_check(`RIDX_FEC_CONTROL, 32'h0);
		send_frame(1'h0, 1'h0, header(8'haa, 4, 32'h904e0000, 2), 48, 1'h0);
		wr(`RIDX_PREAMBLE_PATTERN, 32'h35);
		wr(`RIDX_PREAMBLE_LENGTH, 32'h5);
		wr(`RIDX_SYNC_HEADER_CONTROL, 32'h3);
		wr(`RIDX_TX_DELIM_UNCODED, 32'h904e0000);
		wr(`RIDX_FEC_CONTROL, 32'h2);
		send_frame(1'h0, 1'h0, header(8'h35, 5, 32'h6f4e0000, 4), 72, 1'h1);
		rx_pulse(1'h1);
		rd_check(`RIDX_FRAMER_STATUS, 32'h6);
		wr(`RIDX_FEC_CONTROL, 32'h40);
		wr(`RIDX_PREAMBLE_LENGTH, 32'h4);
		wr(`RIDX_SYNC_HEADER_CONTROL, 32'h0);
		send_frame(1'h1, 1'h0, header(8'h35, 4, 32'h632d0000, 1), 40, 1'h1);
		wr(`RIDX_FEC_CONTROL, 32'h44);
		wr(`RIDX_SYNC_HEADER_CONTROL, 32'h2);
		send_frame(1'h1, 1'h1, header(8'h35, 4, 32'h7a0e0000, 3), 56, 1'h0);
		report_and_stop();
	end

	// Frames take about 22k clocks in all
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule

`default_nettype wire
